// file: hw/tms_regs.vh
// constants for the message-send unit and its register map
//
// Overview of operation
// RQ1 - opcode 49 decodes as message send
// RQ2 - each send appends one request queue entry
// RQ3 - payload and reply use consecutive register runs
// RQ4 - extended descriptor is six-bit instruction immediate
// RQ5 - low four bits select target unit
// RQ6 - finish flag is instruction bit 127
// RQ7 - finish send notifies unit and dispatcher
// RQ8 - descriptor is immediate or address register lead
// RQ9 - register descriptor keeps lower 29 bits
// RQ10 - payload source is 256-bit aligned register
// RQ11 - destination null, direct or indirect only
// RQ12 - null destination means no reply, length zero
// RQ13 - register destination forwarded, phases match length
// RQ14 - empty reply is one phase, lanes off; code sets err_q and writes no phase
// RQ15 - destination fields shape lanes even when null
// RQ16 - 16-bit lane enables travel in sideband
// RQ17 - one lane mask for every reply phase
// RQ18 - data port delays write ack until observable
// RQ19 - send must not suppress dependency clear
// RQ20 - no last register reply when ranges overlap
// RQ21 - request length 1 to 15 in 28:25
// RQ22 - response length 0 to 16 in 24:20
// RQ23 - bit 19 header present, 18:0 passed through
// RQ24 - finishing send uses null destination, no ack
// RQ25 - full queue stalls issue, nothing dropped
`ifndef TMS_REGS_VH
`define TMS_REGS_VH
`define TMS_OPC_SEND      7'h31
`define TMS_DESC_KEEP     32'h1fffffff
`define TMS_RLEN_HI       24
`define TMS_RLEN_LO       20
`define TMS_MLEN_HI       28
`define TMS_MLEN_LO       25
`define TMS_HDR_BIT       19
`define TMS_XD_FIN_BIT    5
`define TMS_NULL_REG      8'h00
`define TMS_LAST_REG      8'h7f
`define TMS_A_CTRL        8'h00
`define TMS_A_STAT        8'h04
`define TMS_A_COUNT       8'h08
`define TMS_A_LAST_DESC   8'h0c
`define TMS_A_LAST_XD     8'h10
`define TMS_A_PHASES      8'h14
`define TMS_CTRL_RST      32'h00000001
`endif

// file: hw/tms_queue.v
// request queue storage: small register-file fifo with registered read data
`default_nettype none
module tms_queue #(
	parameter WIDTH = 64,
	parameter DEPTH_LOG2 = 2
) (
	// clock and reset
	input  wire             i_ref_clk,
	input  wire             i_rstn,
	// write side
	input  wire             i_wr_valid,
	input  wire [WIDTH-1:0] i_wr_data,
	output reg              o_wr_ready,
	// read side
	output reg              o_rd_valid,
	output reg  [WIDTH-1:0] o_rd_data,
	input  wire             i_rd_ready
);
	localparam DEPTH = 1 << DEPTH_LOG2;
	reg [WIDTH-1:0]      mem_q [0:DEPTH-1];
	reg [DEPTH_LOG2:0]   wp_q;
	reg [DEPTH_LOG2:0]   rp_q;
	wire                 empty_w = (wp_q == rp_q);
	wire                 pop_w   = (~o_rd_valid | i_rd_ready) & ~empty_w;
	wire                 push_w  = i_wr_valid & o_wr_ready;
	wire [DEPTH_LOG2:0]  wp_nx_w = wp_q + {{DEPTH_LOG2{1'b0}}, push_w};
	wire [DEPTH_LOG2:0]  rp_nx_w = rp_q + {{DEPTH_LOG2{1'b0}}, pop_w};
	// pointer difference wraps cleanly; top bit set only when full
	wire [DEPTH_LOG2:0]  used_nx_w = wp_nx_w - rp_nx_w;

	always @(posedge i_ref_clk)
	begin
		if (push_w)
			mem_q[wp_q[DEPTH_LOG2-1:0]] <= i_wr_data;
	end

	// read data always from a register so the output stage is clean
	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wp_q       <= {(DEPTH_LOG2+1){1'b0}};
			rp_q       <= {(DEPTH_LOG2+1){1'b0}};
			o_rd_valid <= 1'b0;
			o_rd_data  <= {WIDTH{1'b0}};
			o_wr_ready <= 1'b0;
		end
		else
		begin
			if (push_w)
				wp_q <= wp_q + 1'b1;
			if (pop_w)
			begin
				rp_q      <= rp_q + 1'b1;
				o_rd_data <= mem_q[rp_q[DEPTH_LOG2-1:0]];
				o_rd_valid <= 1'b1;
			end
			else if (i_rd_ready)
				o_rd_valid <= 1'b0;
			// ready follows the occupancy left after this edge
			o_wr_ready <= ~used_nx_w[DEPTH_LOG2];
		end
	end
endmodule // tms_queue
`default_nettype wire

// file: hw/tms_send_unit.v
// message-send execution unit: decode, descriptor forming, request queue, reply tracking
`include "tms_regs.vh"
`default_nettype none
module tms_send_unit #(
	parameter DEPTH_LOG2 = 2
) (
	// clock and reset
	input  wire        i_ref_clk,
	input  wire        i_rstn,
	// instruction issue
	input  wire        i_issue_valid,
	input  wire [6:0]  i_opcode,
	input  wire [7:0]  i_src_reg,
	input  wire [7:0]  i_dst_reg,
	input  wire        i_dst_is_null,
	input  wire [5:0]  i_six_bit_immediate,
	input  wire [31:0] i_word_immediate,
	input  wire        i_desc_from_reg,
	input  wire [31:0] i_address_register_lead,
	input  wire [15:0] i_lane_write_enable,
	output reg         o_issue_ready,
	// outbound request queue head
	output reg         o_req_valid,
	output reg  [3:0]  o_target_unit_id,
	output reg  [28:0] o_req_desc,
	output reg  [7:0]  o_req_src_reg,
	output reg  [7:0]  o_req_resp_reg,
	output reg         o_req_resp_en,
	output reg  [15:0] o_message_lane_enables,
	output reg         o_req_header,
	output reg         o_thread_finish_flag,
	input  wire        i_req_ready,
	// response phases
	input  wire        i_resp_valid,
	output reg         o_resp_wr_en,
	output reg  [7:0]  o_resp_wr_reg,
	output reg  [15:0] o_resp_wr_mask,
	// thread end notice to dispatcher
	output reg         o_thread_end,
	// axi4-lite slave
	input  wire        i_awvalid,
	input  wire [7:0]  i_awaddr,
	output reg         o_awready,
	input  wire        i_wvalid,
	input  wire [31:0] i_wdata,
	input  wire [3:0]  i_wstrb,
	output reg         o_wready,
	output reg         o_bvalid,
	output reg  [1:0]  o_bresp,
	input  wire        i_bready,
	input  wire        i_arvalid,
	input  wire [7:0]  i_araddr,
	output reg         o_arready,
	output reg         o_rvalid,
	output reg  [31:0] o_rdata,
	output reg  [1:0]  o_rresp,
	input  wire        i_rready
);
	localparam QW = 4 + 29 + 8 + 8 + 1 + 16 + 1;

	function [28:0] desc_sel;
		input        from_reg;
		input [31:0] imm;
		input [31:0] areg;
		begin
			desc_sel = from_reg ? areg[28:0] : imm[28:0]; // RQ9
		end
	endfunction

	reg        enable_q;
	reg [15:0] count_q;
	reg [31:0] last_desc_q;
	reg [5:0]  last_xd_q;
	reg [4:0]  phases_left_q;
	reg [7:0]  resp_base_q;
	reg [15:0] resp_mask_q;
	reg        err_q;
	reg        head_busy_q;

	wire       is_send_w  = (i_opcode == `TMS_OPC_SEND); // RQ1
	wire [28:0] desc_w    = desc_sel(i_desc_from_reg, i_word_immediate,
	                                  i_address_register_lead);
	wire       fin_w      = i_six_bit_immediate[`TMS_XD_FIN_BIT]; // RQ6
	wire       q_wready;
	wire       q_rvalid;
	wire [QW-1:0] q_rdata;
	// a new send waits while replies are pending or the queue is full
	wire       can_take_w = enable_q & q_wready & (phases_left_q == 5'd0);
	// only a slot already promised on o_issue_ready is taken
	wire       take_w     = i_issue_valid & is_send_w & o_issue_ready & can_take_w; // RQ2 RQ25
	wire [4:0] rlen_w     = desc_w[`TMS_RLEN_HI:`TMS_RLEN_LO];
	wire       resp_en_w  = ~i_dst_is_null; // RQ12 RQ13
	wire [QW-1:0] entry_w = {i_six_bit_immediate[3:0], // RQ4 RQ5
	                         desc_w, i_src_reg, // RQ3 RQ23
	                         i_dst_reg, resp_en_w,
	                         i_lane_write_enable, fin_w}; // RQ15 RQ16
	// queue output counts as taken only when the head stage loads it
	wire       head_room_w = ~head_busy_q | i_req_ready;

	tms_queue #(
		.WIDTH      (QW),
		.DEPTH_LOG2 (DEPTH_LOG2)
	) u_queue (
		.i_ref_clk  (i_ref_clk),
		.i_rstn     (i_rstn),
		.i_wr_valid (take_w),
		.i_wr_data  (entry_w),
		.o_wr_ready (q_wready),
		.o_rd_valid (q_rvalid),
		.o_rd_data  (q_rdata),
		.i_rd_ready (head_room_w)
	);

	// queue head registered again so every output comes from a flop
	wire       head_take_w = q_rvalid & head_room_w;
	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_issue_ready          <= 1'b0;
			head_busy_q            <= 1'b0;
			o_req_valid            <= 1'b0;
			o_target_unit_id       <= 4'h0;
			o_req_desc             <= 29'h0;
			o_req_src_reg          <= 8'h00;
			o_req_resp_reg         <= 8'h00;
			o_req_resp_en          <= 1'b0;
			o_message_lane_enables <= 16'h0000;
			o_req_header           <= 1'b0;
			o_thread_finish_flag   <= 1'b0;
			o_thread_end           <= 1'b0;
		end
		else
		begin
			// low for a cycle after a take, so it never promises a used slot
			o_issue_ready <= can_take_w & ~take_w;
			o_thread_end  <= take_w & fin_w; // RQ7
			if (o_req_valid & i_req_ready & ~q_rvalid)
			begin
				o_req_valid <= 1'b0;
				head_busy_q <= 1'b0;
			end
			if (head_take_w)
			begin
				o_req_valid            <= 1'b1;
				head_busy_q            <= 1'b1;
				o_target_unit_id       <= q_rdata[QW-1:QW-4];
				o_req_desc             <= q_rdata[QW-5:QW-33];
				o_req_header           <= q_rdata[QW-33+`TMS_HDR_BIT];
				o_req_src_reg          <= q_rdata[33:26];
				o_req_resp_reg         <= q_rdata[25:18];
				o_req_resp_en          <= q_rdata[17];
				o_message_lane_enables <= q_rdata[16:1];
				o_thread_finish_flag   <= q_rdata[0];
			end
		end
	end

	// reply phases land on consecutive registers with one fixed mask
	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			phases_left_q  <= 5'd0;
			resp_base_q    <= 8'h00;
			resp_mask_q    <= 16'h0000;
			o_resp_wr_en   <= 1'b0;
			o_resp_wr_reg  <= 8'h00;
			o_resp_wr_mask <= 16'h0000;
			err_q          <= 1'b0;
		end
		else
		begin
			o_resp_wr_en <= 1'b0;
			if (take_w & resp_en_w)
			begin
				phases_left_q <= rlen_w; // RQ13
				resp_base_q   <= i_dst_reg; // RQ3
				resp_mask_q   <= i_lane_write_enable; // RQ17
				if (rlen_w == 5'd0)
					err_q <= 1'b1;
			end
			else if (i_resp_valid & (phases_left_q != 5'd0))
			begin
				o_resp_wr_en   <= 1'b1;
				o_resp_wr_reg  <= resp_base_q;
				o_resp_wr_mask <= resp_mask_q; // RQ17
				resp_base_q    <= resp_base_q + 8'h01;
				phases_left_q  <= phases_left_q - 5'd1;
			end
			else if (i_resp_valid)
				err_q <= 1'b1;
			if (take_w & ~resp_en_w & (rlen_w != 5'd0))
				err_q <= 1'b1; // RQ12
			if (take_w & fin_w & resp_en_w)
				err_q <= 1'b1; // RQ24
		end
	end

	// software state
	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			count_q     <= 16'h0000;
			last_desc_q <= 32'h00000000;
			last_xd_q   <= 6'h00;
		end
		else if (take_w)
		begin
			count_q     <= count_q + 16'h0001;
			last_desc_q <= {3'b000, desc_w};
			last_xd_q   <= i_six_bit_immediate;
		end
	end

	// axi4-lite write path: address and data taken in either order
	reg        aw_have_q;
	reg        w_have_q;
	reg [7:0]  aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;
	wire       wr_go_w = aw_have_q & w_have_q & ~o_bvalid;
	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= 2'b00;
			enable_q  <= 1'b1;
		end
		else
		begin
			o_awready <= ~aw_have_q & ~(i_awvalid & o_awready);
			o_wready  <= ~w_have_q & ~(i_wvalid & o_wready);
			if (i_awvalid & o_awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= i_awaddr;
			end
			if (i_wvalid & o_wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= i_wdata;
				w_strb_q <= i_wstrb;
			end
			if (wr_go_w)
			begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				o_bvalid  <= 1'b1;
				if (aw_addr_q == `TMS_A_CTRL)
				begin
					o_bresp <= 2'b00;
					if (w_strb_q[0])
						enable_q <= w_data_q[0];
				end
				else if (aw_addr_q == `TMS_A_STAT || aw_addr_q == `TMS_A_COUNT ||
				         aw_addr_q == `TMS_A_LAST_DESC || aw_addr_q == `TMS_A_LAST_XD ||
				         aw_addr_q == `TMS_A_PHASES)
					o_bresp <= 2'b00;
				else
					o_bresp <= 2'b10;
			end
			else if (o_bvalid & i_bready)
				o_bvalid <= 1'b0;
		end
	end

	// axi4-lite read path; status bits live, error bit sticky until reset
	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h00000000;
			o_rresp   <= 2'b00;
		end
		else
		begin
			o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
			if (i_arvalid & o_arready)
			begin
				o_rvalid <= 1'b1;
				o_rresp  <= 2'b00;
				case (i_araddr)
				`TMS_A_CTRL:      o_rdata <= {31'h0, enable_q};
				`TMS_A_STAT:      o_rdata <= {28'h0, o_req_valid, err_q,
				                              ~q_wready, phases_left_q != 5'd0};
				`TMS_A_COUNT:     o_rdata <= {16'h0, count_q};
				`TMS_A_LAST_DESC: o_rdata <= last_desc_q;
				`TMS_A_LAST_XD:   o_rdata <= {26'h0, last_xd_q};
				`TMS_A_PHASES:    o_rdata <= {27'h0, phases_left_q};
				default:
				begin
					o_rdata <= 32'h00000000;
					o_rresp <= 2'b10;
				end
				endcase
			end
			else if (o_rvalid & i_rready)
				o_rvalid <= 1'b0;
		end
	end
endmodule // tms_send_unit
`default_nettype wire

// file: dv/tms_props.sv
// assertion checker on the message-send unit ports
`default_nettype none
module tms_props #(
	parameter DEPTH_LOG2 = 2
) (
	// clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_rstn,
	// issue side
	input wire logic        i_issue_valid,
	input wire logic [6:0]  i_opcode,
	input wire logic [5:0]  i_six_bit_immediate,
	input wire logic        o_issue_ready,
	input wire logic        o_thread_end,
	// queue head
	input wire logic        o_req_valid,
	input wire logic        i_req_ready,
	input wire logic [28:0] o_req_desc,
	input wire logic [3:0]  o_target_unit_id,
	input wire logic        o_req_header,
	// reply phases
	input wire logic        i_resp_valid,
	input wire logic        o_resp_wr_en,
	input wire logic [7:0]  o_resp_wr_reg,
	input wire logic [15:0] o_resp_wr_mask
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	wire take = i_issue_valid && i_opcode == 7'h31 && o_issue_ready;
	wire fin = take && i_six_bit_immediate[5];
	wire run = o_resp_wr_en && i_rstn;

	AST_FIN_PULSE: assert property (fin |=> o_thread_end)
		else $error("finish send gave no thread end");
	AST_FIN_CAUSE: assert property (o_thread_end |-> $past(fin))
		else $error("thread end without finish flag");
	AST_NOT_SEND: assert property (i_issue_valid && i_opcode != 7'h31 |=> !o_thread_end)
		else $error("other opcode acted as send");
	AST_REQ_SOON: assert property (take |-> ##[1:4] o_req_valid)
		else $error("taken send left no queue entry");
	AST_HEAD_HOLD: assert property (o_req_valid && !i_req_ready |=>
		o_req_valid && $stable(o_req_desc) && $stable(o_target_unit_id))
		else $error("queue head dropped or changed");
	AST_HDR: assert property (o_req_valid |-> o_req_header == o_req_desc[19])
		else $error("header flag not descriptor bit 19");
	AST_PHASE_CAUSE: assert property (o_resp_wr_en |-> $past(i_resp_valid))
		else $error("reply write without phase");
	AST_PHASE_NEXT: assert property (run && $past(run) |->
		o_resp_wr_reg == $past(o_resp_wr_reg) + 8'h01)
		else $error("reply registers not consecutive");
	AST_PHASE_MASK: assert property (run && $past(run) |-> $stable(o_resp_wr_mask))
		else $error("reply mask changed between phases");
endmodule // tms_props
`default_nettype wire

// file: dv/tms_far_unit.sv
// behavioural far-side function unit: takes requests, returns reply phases
`default_nettype none
module tms_far_unit (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	// request head
	input  wire logic        i_req_valid,
	input  wire logic [28:0] i_req_desc,
	input  wire logic        i_req_resp_en,
	input  wire logic [7:0]  i_slow,
	output var  logic        o_req_ready,
	// reply phases
	output var  logic        o_resp_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] left_q;
	logic [7:0] wait_q;
	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_req_ready <= 1'b0;
			o_resp_valid <= 1'b0;
			left_q <= 5'h00;
			wait_q <= 8'h00;
		end
		else
		begin
			o_req_ready <= 1'b0;
			o_resp_valid <= 1'b0;
			// phases back to back, as many as the length asks
			if (left_q != 5'h00)
			begin
				o_resp_valid <= 1'b1;
				left_q <= left_q - 5'h01;
			end
			else if (i_req_valid && !o_req_ready)
			begin
				if (wait_q < i_slow)
					wait_q <= wait_q + 8'h01;
				else
				begin
					o_req_ready <= 1'b1;
					wait_q <= 8'h00;
					// no reply at all for a null destination
					if (i_req_resp_en)
						left_q <= i_req_desc[24:20];
				end
			end
		end
	end
endmodule // tms_far_unit
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the message-send unit
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 0, i_rstn = 0, i_issue_valid = 0, i_dst_is_null = 0, i_desc_from_reg = 0;
	logic [6:0] i_opcode = 0;
	logic [7:0] i_src_reg = 8'h10, i_dst_reg = 8'h20, i_awaddr = 0, i_araddr = 0, slow = 0;
	logic [5:0] i_six_bit_immediate = 0;
	logic [31:0] i_word_immediate = 0, i_address_register_lead = 0, i_wdata = 0;
	logic [15:0] i_lane_write_enable = 0;
	logic [3:0] i_wstrb = 4'hf;
	logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
	wire logic i_req_ready, i_resp_valid, o_issue_ready, o_req_valid, o_req_resp_en, o_req_header;
	wire logic o_thread_finish_flag, o_resp_wr_en, o_thread_end, o_awready, o_wready, o_bvalid;
	wire logic o_arready, o_rvalid;
	wire logic [3:0] o_target_unit_id;
	wire logic [28:0] o_req_desc;
	wire logic [7:0] o_req_src_reg, o_req_resp_reg, o_resp_wr_reg;
	wire logic [15:0] o_message_lane_enables, o_resp_wr_mask;
	wire logic [1:0] o_bresp, o_rresp;
	wire logic [31:0] o_rdata;
	int mismatches = 0, total_checks = 0, cyc = 0, ends = 0, wrs = 0, nreq = 0;
	logic [7:0] wr0, wrn, rreg;
	logic [15:0] wmask;
	logic [59:0] hd;

	tms_send_unit #(.DEPTH_LOG2(2)) dut (.i_ref_clk, .i_rstn, .i_issue_valid, .i_opcode,
		.i_src_reg, .i_dst_reg, .i_dst_is_null, .i_six_bit_immediate, .i_word_immediate,
		.i_desc_from_reg, .i_address_register_lead, .i_lane_write_enable, .o_issue_ready,
		.o_req_valid, .o_target_unit_id, .o_req_desc, .o_req_src_reg, .o_req_resp_reg,
		.o_req_resp_en, .o_message_lane_enables, .o_req_header, .o_thread_finish_flag,
		.i_req_ready, .i_resp_valid, .o_resp_wr_en, .o_resp_wr_reg, .o_resp_wr_mask,
		.o_thread_end, .i_awvalid, .i_awaddr, .o_awready, .i_wvalid, .i_wdata, .i_wstrb,
		.o_wready, .o_bvalid, .o_bresp, .i_bready, .i_arvalid, .i_araddr, .o_arready,
		.o_rvalid, .o_rdata, .o_rresp, .i_rready);
	tms_far_unit far (.i_ref_clk, .i_rstn, .i_req_valid(o_req_valid), .i_req_desc(o_req_desc),
		.i_req_resp_en(o_req_resp_en), .i_slow(slow), .o_req_ready(i_req_ready),
		.o_resp_valid(i_resp_valid));

	always #10 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			summarize();
		end
	end
	// sampled mid-cycle so the values equal those seen at the next edge
	always @(negedge i_ref_clk)
	begin
		if (o_thread_end === 1'b1)
			ends++;
		if (o_resp_wr_en === 1'b1)
		begin
			if (wrs == 0)
				wr0 = o_resp_wr_reg;
			wrn = o_resp_wr_reg;
			wmask = o_resp_wr_mask;
			wrs++;
		end
		if (o_req_valid === 1'b1 && i_req_ready === 1'b1)
		begin
			nreq++;
			rreg = o_req_resp_reg;
			hd = {o_thread_finish_flag, o_req_header, o_req_resp_en, o_target_unit_id,
				o_req_src_reg, o_message_lane_enables, o_req_desc};
		end
	end

	task automatic chk(input logic [59:0] got, input logic [59:0] exp, input string m);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ha, hw, hd2;
		@(posedge i_ref_clk);
		i_awvalid <= wr;
		i_wvalid <= wr;
		i_bready <= wr;
		i_arvalid <= !wr;
		i_rready <= !wr;
		i_awaddr <= a;
		i_araddr <= a;
		i_wdata <= d;
		hd2 = 0;
		while (!hd2)
		begin
			@(negedge i_ref_clk);
			ha = i_awvalid & o_awready | i_arvalid & o_arready;
			hw = i_wvalid & o_wready;
			hd2 = i_bready & o_bvalid | i_rready & o_rvalid;
			if (hd2 && !wr)
				chk(o_rdata, d, "read data");
			if (hd2)
				chk(wr ? o_bresp : o_rresp, er, "response");
			@(posedge i_ref_clk);
			if (ha)
			begin
				i_awvalid <= 0;
				i_arvalid <= 0;
			end
			if (hw)
				i_wvalid <= 0;
			if (hd2)
			begin
				i_bready <= 0;
				i_rready <= 0;
			end
		end
	endtask

	// held until the unit takes it; another opcode is offered for one edge
	task automatic send(input logic [6:0] op, input logic [5:0] x, input logic nul,
		input logic fr, input logic [31:0] dw, input logic [15:0] ln);
		logic tk;
		@(posedge i_ref_clk);
		i_issue_valid <= 1;
		i_opcode <= op;
		i_six_bit_immediate <= x;
		i_dst_is_null <= nul;
		i_desc_from_reg <= fr;
		i_word_immediate <= fr ? 32'h0 : dw;
		i_address_register_lead <= fr ? dw : ~dw;
		i_lane_write_enable <= ln;
		tk = 0;
		while (!tk)
		begin
			@(negedge i_ref_clk);
			tk = o_issue_ready | (op != 7'h31);
			@(posedge i_ref_clk);
		end
		i_issue_valid <= 0;
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge i_ref_clk);
		i_rstn <= 1;
		repeat (2) @(posedge i_ref_clk);
		axi(0, 8'h00, 32'h1, 2'b00);
		axi(0, 8'h04, 32'h0, 2'b00);
		axi(0, 8'h40, 32'h0, 2'b10);
		axi(1, 8'h40, 32'h5, 2'b10);
		axi(1, 8'h00, 32'h1, 2'b00);
		$display("test registers done");
		send(7'h31, 6'h07, 0, 0, 32'h04381234, 16'h00ff);
		while (wrs < 3)
			@(negedge i_ref_clk);
		repeat (4) @(negedge i_ref_clk);
		chk(hd, {3'b011, 4'h7, 8'h10, 16'h00ff, 29'h04381234}, "head");
		chk({wr0, wrn, wmask}, {8'h20, 8'h22, 16'h00ff}, "reply");
		chk(wrs, 3, "phases");
		chk(rreg, 8'h20, "reply lead");
		$display("test reply done");
		send(7'h31, 6'h2c, 1, 1, 32'he4081234, 16'ha5a5);
		while (nreq < 2)
			@(negedge i_ref_clk);
		chk(hd, {3'b110, 4'hc, 8'h10, 16'ha5a5, 29'h04081234}, "finish head");
		chk(ends, 1, "thread end");
		send(7'h30, 6'h27, 1, 0, 32'h02000000, 16'hffff);
		repeat (10) @(negedge i_ref_clk);
		chk({nreq, ends}, {32'd2, 32'd1}, "other opcode");
		$display("test finish done");
		slow <= 8'd20;
		for (int k = 0; k < 7; k++)
			send(7'h31, 6'h01, 1, 0, 32'h02000000 | k, 16'h0001);
		while (nreq < 9)
			@(negedge i_ref_clk);
		chk(hd[28:0], 29'h02000006, "last entry");
		axi(0, 8'h08, 32'h9, 2'b00);
		$display("test queue full done");
		send(7'h31, 6'h01, 1, 0, 32'h02100000, 16'h0001);
		while (nreq < 10)
			@(negedge i_ref_clk);
		axi(0, 8'h04, 32'h4, 2'b00);
		$display("test error flag done");
		summarize();
	end
endmodule // tb

bind tms_send_unit tms_props #(.DEPTH_LOG2(DEPTH_LOG2)) u_props (.i_ref_clk, .i_rstn,
	.i_issue_valid, .i_opcode, .i_six_bit_immediate, .o_issue_ready, .o_thread_end,
	.o_req_valid, .i_req_ready, .o_req_desc, .o_target_unit_id, .o_req_header,
	.i_resp_valid, .o_resp_wr_en, .o_resp_wr_reg, .o_resp_wr_mask);
`default_nettype wire
